// File: rtl/pac_pkg.sv
// package: register map, field positions and widths for the pwm align block
package pac_pkg;
    // ==========================================================
    // widths
    localparam int PAC_CH       = 6;         // channel count
    localparam int PAC_DW       = 8;         // register data width
    localparam int PAC_AW       = 5;         // register address width
    // ==========================================================
    // register offsets
    localparam logic [4:0] PAC_OFS_ENABLE  = 5'h00; // channel_enable_bit
    localparam logic [4:0] PAC_OFS_POL     = 5'h01; // polarity_bit
    localparam logic [4:0] PAC_OFS_CLKSEL  = 5'h02; // clock_select_bit
    localparam logic [4:0] PAC_OFS_PRESC   = 5'h03; // prescale select
    localparam logic [4:0] PAC_OFS_ALIGN   = 5'h04; // center_align_select
    localparam logic [4:0] PAC_OFS_CTRL    = 5'h05; // module_control
    localparam logic [4:0] PAC_OFS_PER0    = 5'h12; // period, channel 0
    localparam logic [4:0] PAC_OFS_DTY0    = 5'h18; // duty, channel 0
    // ==========================================================
    // module_control fields
    localparam int PAC_B_JOIN_HI   = 6;  // join_pair_hi (4+5)
    localparam int PAC_B_JOIN_MID  = 5;  // join_pair_mid (2+3)
    localparam int PAC_B_JOIN_LO   = 4;  // join_pair_lo (0+1)
    localparam int PAC_B_WAIT_STOP = 3;  // wait_stop_bit
    localparam int PAC_B_FRZ_STOP  = 2;  // freeze_stop_bit
    localparam logic [7:0] PAC_CTRL_MASK  = 8'h7c; // implemented bits
    localparam logic [7:0] PAC_CH_MASK    = 8'h3f; // six channel bits
    localparam logic [7:0] PAC_PRESC_MASK = 8'h77; // two 3-bit fields
    // ==========================================================
    // reset values
    localparam logic [7:0] PAC_RST_REG   = 8'h00;
    localparam logic [7:0] PAC_RST_PER   = 8'hff;
    localparam logic [7:0] PAC_RST_DTY   = 8'hff;
    localparam logic [6:0] PAC_RST_PRE   = 7'h00;
endpackage : pac_pkg

// File: rtl/pac_channel.sv
// one pwm channel that runs as 8-bit or as a 16-bit joined pair
`timescale 1ns/1ps
`default_nettype none
module pac_channel
(
    // clock and reset
    input  wire  logic        i_ref_clk,
    input  wire  logic        i_rst_n,
    input  wire  logic        i_ce,
    // control
    input  wire  logic        i_tick,     // channel clock tick
    input  wire  logic        i_enable,
    input  wire  logic        i_center,   // center aligned mode
    input  wire  logic        i_pol,
    input  wire  logic        i_wide,     // 16-bit mode
    input  wire  logic [15:0] i_period,
    input  wire  logic [15:0] i_duty,
    // output
    output logic              o_wave
);
    // ==========================================================
    // state
    logic [15:0] count;       // up/down counter
    logic        down;        // counting down (center mode)
    logic [15:0] per_act;     // active period latch
    logic [15:0] dty_act;     // active duty latch
    wire  [15:0] msk       = i_wide ? 16'hffff : 16'h00ff;
    wire  [15:0] per_m     = i_period & msk;
    wire  [15:0] dty_m     = i_duty & msk;
    wire  [15:0] per_dec   = per_act - 16'h0001;
    wire         at_top    = (count >= per_dec);
    // left: wrap at period-1; center: reverse at period, end at zero [R13]
    wire         lend      = !i_center && at_top;
    wire         cend      = i_center && down && (count <= 16'h0001);
    wire         pend      = lend || cend;
    wire         turn      = i_center && !down && (count >= per_act);
    // the down slope includes the match count, so center high time is
    // twice the duty value, from the duty count going down to duty-1 going up
    wire         below     = down ? (count <= dty_act)
                                  : (count < dty_act);
    // ==========================================================
    // counter and buffered latch update; disabled channel loads straight
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            count   <= 16'h0000;
            down    <= 1'b0;
            per_act <= 16'h0000;
            dty_act <= 16'h0000;
            o_wave  <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!i_enable)
            begin
                // latches follow the buffer while idle
                per_act <= per_m;
                dty_act <= dty_m;
                o_wave  <= i_pol;
            end
            else if (i_tick)
            begin
                if (pend)
                begin
                    count   <= 16'h0000;
                    down    <= 1'b0;
                    per_act <= per_m;
                    dty_act <= dty_m;
                end
                else if (turn)
                begin
                    down  <= 1'b1;
                    count <= count - 16'h0001;
                end
                else if (down)
                    count <= count - 16'h0001;
                else
                    count <= count + 16'h0001;
                // polarity chooses the level before the duty match
                o_wave <= below ? i_pol : !i_pol;
            end
        end
    end
endmodule : pac_channel
`default_nettype wire

// File: rtl/pac_top.sv
// pwm alignment and concatenation control with a small channel core
//
// Functional notes
// (R1) alignment bit: 0 left, 1 center
// (R2) software changes alignment only while disabled
// (R3) three join bits merge channel pairs
// (R4) join bit 6: ch4 high, ch5 low, pin 5
// (R5) join bit 5: ch2 high, ch3 low, pin 3
// (R6) join bit 4: ch0 high, ch1 low, pin 1
// (R7) joined pair uses low channel controls
// (R8) clear join bit: independent 8-bit channels
// (R9) software changes join only while disabled
// (R10) wait_stop_bit gates prescaler in wait
// (R11) freeze_stop_bit gates prescaler in freeze
// (R12) registers stay accessible; clock resumes at once
// (R13) center counts up-down; left to period-1
// (R14) alignment and control reset to zero
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pac_top
    import pac_pkg::*;
(
    // clock, reset, clock enable
    input  wire  logic                 i_ref_clk,
    input  wire  logic                 i_rst_n,
    input  wire  logic                 i_ce,
    // processor mode inputs
    input  wire  logic                 i_wait_mode,
    input  wire  logic                 i_freeze_mode,
    // register port
    input  wire  logic [pac_pkg::PAC_AW-1:0] i_addr,
    input  wire  logic [pac_pkg::PAC_DW-1:0] i_wdata,
    input  wire  logic                 i_wr,
    input  wire  logic                 i_rd,
    output logic [pac_pkg::PAC_DW-1:0] o_rdata,
    // output_port pins
    output logic [pac_pkg::PAC_CH-1:0] o_output_port,
    output logic                       o_presc_run
);
    import pac_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] chan_enable;    // channel_enable_bit per channel
    logic [7:0] chan_pol;       // polarity_bit per channel
    logic [7:0] chan_clksel;    // clock_select_bit per channel
    logic [7:0] presc_sel;      // clock a and b prescale
    logic [7:0] center_align_select; // center_align_bit per channel
    logic [7:0] module_control;
    logic [7:0] period [PAC_CH];  // period buffers
    logic [7:0] duty   [PAC_CH];  // duty buffers
    logic [6:0] presc_cnt;      // free prescaler
    logic [6:0] presc_prev;     // prescaler value one tick ago

    // ==========================================================
    // decode
    wire wr_en   = i_wr && i_ce;
    wire w_enab  = wr_en && (i_addr == PAC_OFS_ENABLE);
    wire w_pol   = wr_en && (i_addr == PAC_OFS_POL);
    wire w_clks  = wr_en && (i_addr == PAC_OFS_CLKSEL);
    wire w_pres  = wr_en && (i_addr == PAC_OFS_PRESC);
    wire w_algn  = wr_en && (i_addr == PAC_OFS_ALIGN);
    wire w_ctrl  = wr_en && (i_addr == PAC_OFS_CTRL);
    wire [4:0] per_idx = i_addr - PAC_OFS_PER0;
    wire [4:0] dty_idx = i_addr - PAC_OFS_DTY0;
    wire in_per  = (i_addr >= PAC_OFS_PER0) &&
                   (per_idx < 5'(PAC_CH));
    wire in_dty  = (i_addr >= PAC_OFS_DTY0) &&
                   (dty_idx < 5'(PAC_CH));

    // join bits, one per pair; index is the pair number [R3]
    wire [2:0] join_bits = {module_control[PAC_B_JOIN_HI],   // [R4]
                            module_control[PAC_B_JOIN_MID],  // [R5]
                            module_control[PAC_B_JOIN_LO]};  // [R6]

    // ==========================================================
    // prescaler gating: wait and freeze stop the input clock
    wire gate_wait = module_control[PAC_B_WAIT_STOP] && i_wait_mode; // [R10]
    wire gate_frz  = module_control[PAC_B_FRZ_STOP] && i_freeze_mode; // [R11]
    // combinational so the clock returns the cycle the cause ends [R12]
    wire presc_on  = !(gate_wait || gate_frz);
    wire [6:0] presc_nxt = presc_cnt + 7'h01;
    // prescaler bits set in the next value and clear in presc_prev, two counts back; bit 0 means undivided
    wire [7:0] presc_tick = {~presc_prev & presc_nxt, 1'b1};
    wire [2:0] sel_a = presc_sel[2:0];
    wire [2:0] sel_b = presc_sel[6:4];
    wire tick_a = presc_on && presc_tick[sel_a];
    wire tick_b = presc_on && presc_tick[sel_b];

    // ==========================================================
    // read mux; unmapped offsets read zero
    wire [7:0] rd_per = in_per ? period[per_idx[2:0]] : 8'h00;
    wire [7:0] rd_dty = in_dty ? duty[dty_idx[2:0]] : 8'h00;
    wire [7:0] rd_val =
        (i_addr == PAC_OFS_ENABLE) ? chan_enable :
        (i_addr == PAC_OFS_POL)    ? chan_pol :
        (i_addr == PAC_OFS_CLKSEL) ? chan_clksel :
        (i_addr == PAC_OFS_PRESC)  ? presc_sel :
        (i_addr == PAC_OFS_ALIGN)  ? center_align_select :
        (i_addr == PAC_OFS_CTRL)   ? module_control :
        (rd_per | rd_dty);

    // ==========================================================
    // control registers; reset to zero leaves all left aligned
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            chan_enable         <= PAC_RST_REG;
            chan_pol            <= PAC_RST_REG;
            chan_clksel         <= PAC_RST_REG;
            presc_sel           <= PAC_RST_REG;
            center_align_select <= PAC_RST_REG; // [R14]
            module_control      <= PAC_RST_REG; // [R14]
        end
        else
        begin
            if (w_enab)
                chan_enable <= i_wdata & PAC_CH_MASK;
            if (w_pol)
                chan_pol <= i_wdata & PAC_CH_MASK;
            if (w_clks)
                chan_clksel <= i_wdata & PAC_CH_MASK;
            if (w_pres)
                presc_sel <= i_wdata & PAC_PRESC_MASK;
            // no guard: alignment safety is left to software
            if (w_algn)
                center_align_select <= i_wdata & PAC_CH_MASK;
            // writes allowed in freeze as well [R12]
            if (w_ctrl)
                module_control <= i_wdata & PAC_CTRL_MASK;
        end
    end

    // ==========================================================
    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_ce)
            o_rdata <= i_rd ? rd_val : 8'h00;
    end

    // ==========================================================
    // prescaler counter, held while gated
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            presc_cnt  <= PAC_RST_PRE;
            presc_prev <= PAC_RST_PRE;
            o_presc_run <= 1'b0;
        end
        else if (i_ce)
        begin
            o_presc_run <= presc_on;
            if (presc_on)
            begin
                presc_prev <= presc_cnt;
                presc_cnt  <= presc_nxt;
            end
        end
    end

    // ==========================================================
    // period and duty buffers, one slot per channel
    genvar g;
    generate
        for (g = 0; g < PAC_CH; g++)
        begin : g_buf
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_rst_n)
                begin
                    period[g] <= PAC_RST_PER;
                    duty[g]   <= PAC_RST_DTY;
                end
                else
                begin
                    if (wr_en && in_per && (per_idx[2:0] == 3'(g)))
                        period[g] <= i_wdata;
                    if (wr_en && in_dty && (dty_idx[2:0] == 3'(g)))
                        duty[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // channels; odd channel carries the joined pair
    logic [PAC_CH-1:0] wave;
    generate
        for (g = 0; g < PAC_CH; g++)
        begin : g_ch
            localparam int PAIR = g / 2;
            localparam bit ODD  = (g % 2) == 1;
            // channels 2,3 use clock b, the rest clock a
            wire tk   = (PAIR == 1) ? tick_b : tick_a;
            wire jn   = join_bits[PAIR];
            // high channel silent while joined, low keeps all controls [R7]
            wire en   = chan_enable[g] && !(jn && !ODD);
            // alignment bit picks left or center per channel [R1]
            wire ctr  = center_align_select[g];
            // joined: even register is high byte, odd is low [R4] [R5] [R6]
            wire [15:0] per = (jn && ODD) ? {period[g-(ODD?1:0)], period[g]}
                                          : {8'h00, period[g]};
            wire [15:0] dty = (jn && ODD) ? {duty[g-(ODD?1:0)], duty[g]}
                                          : {8'h00, duty[g]};
            // clock select bit kept; scaled clocks live elsewhere
            pac_channel u_ch
            (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (i_rst_n),
                .i_ce      (i_ce),
                .i_tick    (tk),
                .i_enable  (en),
                .i_center  (ctr),
                .i_pol     (chan_pol[g]),
                .i_wide    (jn && ODD),   // [R8]
                .i_period  (per),
                .i_duty    (dty),
                .o_wave    (wave[g])
            );
        end
    endgenerate

    // ==========================================================
    // output port register; joined high pin is held low
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_output_port <= 6'h00;
        else if (i_ce)
            o_output_port <= wave & ~{1'b0, join_bits[2], 1'b0,
                                      join_bits[1], 1'b0, join_bits[0]};
    end
endmodule : pac_top
`default_nettype wire

// File: bench/pac_checker.sv
// checker: register port and prescaler gating properties of pac_top
`timescale 1ns/1ps
`default_nettype none
module pac_checker
    import pac_pkg::*;
(
    // clock, reset, enable
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_ce,
    // processor modes
    input  wire logic                          i_wait_mode,
    input  wire logic                          i_freeze_mode,
    // register port
    input  wire logic [pac_pkg::PAC_AW-1:0]    i_addr,
    input  wire logic [pac_pkg::PAC_DW-1:0]    i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    input  wire logic [pac_pkg::PAC_DW-1:0]    o_rdata,
    // pins
    input  wire logic [pac_pkg::PAC_CH-1:0]    o_output_port,
    input  wire logic                          o_presc_run
);
    // ==========================================================
    // shadow of module_control, built from the bus alone
    logic [7:0] ctl;                       // mirrored control bits
    wire  logic wr_ctl = i_ce && i_wr && i_addr == PAC_OFS_CTRL;
    // mirror update; masked so unused bits never count
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            ctl <= 8'h00;
        else if (wr_ctl)
            ctl <= i_wdata & PAC_CTRL_MASK;
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_rd_idle_zero: assert property (o_rdata != 8'h00 |-> $past(i_rd && i_ce))
        else $error("read data without a read");
    chk_ctl_read_back: assert property (i_rd && i_ce && i_addr == PAC_OFS_CTRL
        |=> o_rdata == $past(ctl)) else $error("control read back wrong");
    chk_align_used_bits: assert property (i_rd && i_ce && i_addr == PAC_OFS_ALIGN
        |=> (o_rdata & ~PAC_CH_MASK) == 8'h00) else $error("align spare bits");
    chk_unmapped_zero: assert property (i_rd && i_ce && i_addr == 5'h06
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    chk_gate_wait: assert property (i_ce && ctl[PAC_B_WAIT_STOP] && i_wait_mode
        |=> !o_presc_run) else $error("prescaler runs in wait");
    chk_gate_freeze: assert property (i_ce && ctl[PAC_B_FRZ_STOP]
        && i_freeze_mode |=> !o_presc_run) else $error("prescaler runs in freeze");
    chk_run_free: assert property (i_ce && !(ctl[3] && i_wait_mode)
        && !(ctl[2] && i_freeze_mode) |=> o_presc_run) else $error("prescaler stopped");
    chk_join_lo_even: assert property (ctl[PAC_B_JOIN_LO] [*3]
        |-> !o_output_port[0]) else $error("pin 0 active while joined");
    chk_join_mid_even: assert property (ctl[PAC_B_JOIN_MID] [*3]
        |-> !o_output_port[2]) else $error("pin 2 active while joined");
    chk_join_hi_even: assert property (ctl[PAC_B_JOIN_HI] [*3]
        |-> !o_output_port[4]) else $error("pin 4 active while joined");
endmodule // pac_checker

bind pac_top pac_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_wait_mode(i_wait_mode), .i_freeze_mode(i_freeze_mode),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_output_port(o_output_port),
    .o_presc_run(o_presc_run));
`default_nettype wire

// File: bench/tb_top.sv
// testbench: registers, alignment, pair joining and prescaler gating
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pac_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic       i_ref_clk = 1'b0;
    logic       i_rst_n = 1'b0;       // held low for three cycles
    logic       i_ce = 1'b1;          // tied: freeze by enable untested
    logic       i_wait_mode = 1'b0;
    logic       i_freeze_mode = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    wire  logic [7:0] o_rdata;
    wire  logic [5:0] o_output_port;
    wire  logic       o_presc_run;
    int         n_fail = 0;           // mismatches
    int         n_tests = 0;          // comparisons
    int         cyc = 0;              // watchdog count
    pac_top u_pac_top (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_wait_mode(i_wait_mode),
        .i_freeze_mode(i_freeze_mode), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_output_port(o_output_port), .o_presc_run(o_presc_run));
    // ==========================================================
    // clock and watchdog; whole run needs well under 20000 cycles
    initial
    begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // advance n edges and let their updates land
    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // one-cycle write strobe; gap cycle before the next access
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] e,
                      input string nm);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, o_rdata});
    endtask
    // period and high time of one pin, from rise to rise
    task automatic meas(input int b, output int per, output int hi);
        int k;
        k = 0;
        hi = 0;
        while (o_output_port[b] !== 1'b0 && k < 900) begin settle(1); k++; end
        while (o_output_port[b] !== 1'b1 && k < 900) begin settle(1); k++; end
        while (o_output_port[b] === 1'b1 && k < 900) begin settle(1); k++; hi++; end
        per = hi;
        while (o_output_port[b] === 1'b0 && k < 900) begin settle(1); k++; per++; end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(PAC_OFS_ALIGN, 8'h00, "align reset");
        rd(PAC_OFS_CTRL, 8'h00, "ctrl reset");
        wr(PAC_OFS_CTRL, 8'hff);
        rd(PAC_OFS_CTRL, 8'h7c, "ctrl bits");
        wr(PAC_OFS_ALIGN, 8'hff);
        rd(PAC_OFS_ALIGN, 8'h3f, "align bits");
        rd(5'h06, 8'h00, "unmapped");
        wr(PAC_OFS_CTRL, 8'h00);
    endtask
    // every channel left then center; all six change mode together
    task automatic t_align();
        int c, m, p, h;
        for (c = 0; c < 6; c++)
        begin
            wr(PAC_OFS_PER0 + 5'(c), 8'h06);
            wr(PAC_OFS_DTY0 + 5'(c), 8'h02);
        end
        wr(PAC_OFS_POL, 8'h3f);
        for (m = 0; m < 2; m++)
        begin
            wr(PAC_OFS_ENABLE, 8'h00);
            wr(PAC_OFS_ALIGN, m ? 8'h3f : 8'h00);
            wr(PAC_OFS_ENABLE, 8'h3f);
            for (c = 0; c < 6; c++)
            begin
                meas(c, p, h);
                chk("period", 16'(6 << m), 16'(p));
                chk("high time", 16'(2 << m), 16'(h));
            end
        end
    endtask
    // each pair joined; high channel asks for center mode, ignored
    task automatic t_join();
        int q, e, p, h;
        for (q = 0; q < 3; q++)
        begin
            e = 2 * q;
            wr(PAC_OFS_ENABLE, 8'h00);
            wr(PAC_OFS_PER0 + 5'(e), 8'h01);
            wr(PAC_OFS_PER0 + 5'(e + 1), 8'h04);
            wr(PAC_OFS_DTY0 + 5'(e), 8'h00);
            wr(PAC_OFS_DTY0 + 5'(e + 1), 8'h41);
            wr(PAC_OFS_ALIGN, 8'(1 << e));
            wr(PAC_OFS_POL, 8'(3 << e));
            wr(PAC_OFS_CTRL, 8'(8'h10 << q));
            wr(PAC_OFS_ENABLE, 8'(2 << e));
            meas(e + 1, p, h);
            chk("joined period", 16'd260, 16'(p));
            chk("joined high", 16'd65, 16'(h));
            chk("even pin", 16'h0, {15'h0, o_output_port[e]});
        end
    endtask
    // last joined pair holds its pins while the prescaler is gated
    task automatic t_gate();
        logic [5:0] snap;
        wr(PAC_OFS_CTRL, 8'h4c);
        i_wait_mode <= 1'b1;
        settle(3);
        chk("wait gate", 16'h0, {15'h0, o_presc_run});
        @(posedge i_ref_clk);
        i_wait_mode <= 1'b0;
        i_freeze_mode <= 1'b1;
        settle(3);
        snap = o_output_port;
        chk("freeze gate", 16'h0, {15'h0, o_presc_run});
        settle(300);
        chk("frozen pins", {10'h0, snap}, {10'h0, o_output_port});
        rd(PAC_OFS_CTRL, 8'h4c, "ctrl in freeze");
        wr(PAC_OFS_CTRL, 8'h48);
        settle(2);
        chk("resume bit", 16'h1, {15'h0, o_presc_run});
        wr(PAC_OFS_CTRL, 8'h44);
        settle(2);
        chk("freeze again", 16'h0, {15'h0, o_presc_run});
        @(posedge i_ref_clk);
        i_freeze_mode <= 1'b0;
        settle(2);
        chk("resume exit", 16'h1, {15'h0, o_presc_run});
        wr(PAC_OFS_CTRL, 8'h40);
        i_wait_mode <= 1'b1;
        i_freeze_mode <= 1'b1;
        settle(2);
        chk("run in modes", 16'h1, {15'h0, o_presc_run});
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_align();
        t_join();
        t_gate();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
